//--- dv/ssl_link_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Far end of the serial link
// ----------------------------------------
module ssl_link_model (
    input wire logic serial_out,
    input wire logic serial_out_en,
    output logic serial_in
);
    // Released line floats high, as fail-safe bias pulls it: no edges, no boundary
    assign serial_in = serial_out_en ? serial_out : 1'b1;
endmodule // ssl_link_model

//--- dv/ssl_top_bench.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the link sync and lock block
// ----------------------------------------
module ssl_top_bench;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, wclk = 0, req_a = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [9:0] din = 0, word;
    logic awready, wready, bvalid, arready, rvalid, ser, ser_en, ser_in, pen, rclk, lock_n;
    int n_fail = 0, num_checks = 0, cyc = 0, i;
    always #2 aclk = ~aclk; // Running reference clock
    always #24 wclk = ~wclk; // Word clock, 12 aclk per period
    ssl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .transmit_word_clock(wclk),
        .parallel_in_word(din), .sync_request_a(req_a), .sync_request_b(1'b0), .serial_out(ser),
        .serial_out_en(ser_en), .serial_in(ser_in), .parallel_out_word(word), .parallel_out_en(pen),
        .recovered_clock(rclk), .link_lock_n(lock_n));
    ssl_link_model far (.serial_out(ser), .serial_out_en(ser_en), .serial_in(ser_in));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, well past the longest lock wait
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            print_verdict;
        end
    end
    // Address and data offered together, each released when taken
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awv && awready) begin ad = 1; awv <= 0; end
            if (wv && wready) begin wd = 1; wv <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1);
        bready <= 0;
        chk("bresp", bresp, exp);
        @(posedge aclk); // Next call must not re-drive bready in this step
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a; arv <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1);
        arv <= 0;
        do @(posedge aclk); while (rvalid !== 1);
        rready <= 0;
        chk("rdata", rdata, exp);
        chk("rresp", rresp, er);
        @(posedge aclk); // Next call must not re-drive rready in this step
    endtask
    task wait_lock(input logic v);
        for (i = 0; i < 4000 && lock_n !== v; i++) @(posedge aclk);
    endtask
    // Alternating word is a multi-transition pattern: no lock until data changes
    task t_data_lock;
        chk("lock_idle", lock_n, 1'b1);
        chk("oe_idle", ser_en, 1'b0);
        din <= 10'h155;
        repeat (400) @(posedge aclk);
        chk("oe_on", ser_en, 1'b1);
        chk("lock_rmt", lock_n, 1'b1);
        rd(ssl_pkg::REG_STATUS, 32'h19, ssl_pkg::RESP_OKAY);
        din <= 10'h3ff;
        wait_lock(0);
        repeat (30) @(posedge aclk); // Two and a half frames, so a whole word is out
        chk("lock", lock_n, 1'b0);
        chk("pen", pen, 1'b1);
        chk("word", word, 10'h3ff);
        rd(4'h4, 32'h15, ssl_pkg::RESP_OKAY);
        rd(4'hc, 32'h0, ssl_pkg::RESP_SLVERR);
        wr(4'hc, 32'h0, ssl_pkg::RESP_SLVERR);
        // Locked link keeps lock on the same multi-transition word
        din <= 10'h155;
        repeat (60) @(posedge aclk);
        chk("lock_held", lock_n, 1'b0);
        chk("word_rmt", word, 10'h155);
        $display("done data lock");
    endtask
    // Transmitter released: boundary vanishes, lock must drop
    task t_loss;
        wr(ssl_pkg::REG_CTRL, 32'h0, ssl_pkg::RESP_OKAY);
        wait_lock(1);
        chk("lock_lost", lock_n, 1'b1);
        chk("pen_off", pen, 1'b0);
        chk("word_off", word, 10'h0);
        $display("done loss");
    endtask
    // Held request sends sync words; data input is ignored
    task t_sync;
        req_a <= 1; // Request held while unlocked, as lock status would
        wr(ssl_pkg::REG_CTRL, 32'h2, ssl_pkg::RESP_OKAY);
        wait_lock(0);
        for (i = 0; i < 400 && word !== ssl_pkg::SYNC_DATA; i++) @(posedge aclk);
        chk("sync_word", word, ssl_pkg::SYNC_DATA);
        chk("sync_lock", lock_n, 1'b0);
        req_a <= 0;
        $display("done sync");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        chk("rst_lock", lock_n, 1'b1);
        aresetn <= 1;
        t_data_lock;
        t_loss;
        t_sync;
        print_verdict;
    end
endmodule // ssl_top_bench

//--- inc/ssl_pkg.sv
// Function
// - Both ends initialized before any data word
// - Serial output high impedance until initialized
// - Sync pattern: six ones, six zeros
// - Request over 6 cycles sends 1026 syncs
// - Input edges start receive clock acquisition
// - Lock status high hunting, low locked
// - Locked: parallel word, clock follow input
// - Lock possible on random data; code counts only single-boundary words toward lock
// - Multi-transition pattern blocks lock indication
// - Lock after four same boundary words
// - Locked ignores multi-transitions if boundary holds
// - Four boundary misses drop lock, rehunt
// - Unlocked: status high, outputs high impedance
// - Frame: start bit high, stop low
// - Twelve bits per word clock period
// - Parallel input ignored during sync burst
package ssl_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RX_INIT_NS = 400;
    localparam logic [6:0] RX_INIT_CYC = 7'((RX_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] TX_INIT_EDGES = 5'h10;
    // ------------------------------------------------------------
    // Line coding
    // ------------------------------------------------------------
    localparam logic [3:0] FRAME_BITS = 4'hc;
    localparam logic [3:0] RCLK_HIGH = 4'h6;
    localparam logic START_BIT = 1'b1;
    localparam logic STOP_BIT = 1'b0;
    localparam logic [9:0] SYNC_DATA = 10'h01f;
    localparam logic [2:0] SYNC_MIN_WORDS = 3'h6;
    localparam logic [2:0] REQ_SAT = 3'h7;
    localparam logic [10:0] SYNC_BURST_WORDS = 11'h402;
    localparam logic [2:0] BOUNDARY_RUN = 3'h4;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RXWORD = 4'h8;
    localparam int CTRL_SYNC = 0;
    localparam int CTRL_TXEN = 1;
    localparam logic CTRL_TXEN_RST = 1'b1;
    localparam int ST_TX_READY = 0;
    localparam int ST_BURST = 1;
    localparam int ST_LOCKED = 2;
    localparam int ST_RMT = 3;
    localparam int ST_RX_READY = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RX_INIT, RX_IDLE, RX_HUNT, RX_LOCK} ssl_rx_state_type;
    typedef struct packed {
        logic ready;
        logic oe;
        logic lock_n;
        logic repetitive_transition_pattern;
        logic rclk;
        logic [9:0] word;
    } ssl_rx_type;
    typedef struct packed {
        logic wclk;
        logic req_a;
        logic req_b;
        logic ser;
        logic [9:0] din;
    } ssl_pins_type;
endpackage

//--- rtl/ssl_rx.sv
`timescale 1ns/1ns
module ssl_rx (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_in,
    output ssl_pkg::ssl_rx_type status
);
    ssl_pkg::ssl_rx_state_type state, next_state;
    ssl_pkg::ssl_rx_type next_status;
    logic [3:0] ph, next_ph, pos, next_pos, idx, nrise, sp, rel, last;
    logic [11:0] win, next_win, w, rise;
    logic [9:0] dsh, next_dsh;
    logic [2:0] cnt, next_cnt;
    logic [6:0] init, next_init;
    logic prev, next_prev, hit;

    // ------------------------------------------------------------
    // Boundary search
    // ------------------------------------------------------------
    // Current word window, newest sample in its phase slot
    always_comb begin
        w = win;
        w[ph] = serial_in;
    end
    // Stop low followed by start high, one detector per phase
    for (genvar i = 0; i < ssl_pkg::FRAME_BITS; i++) begin : g_rise
        assign rise[i] = !w[i] && w[(i + 1) % ssl_pkg::FRAME_BITS];
    end
    always_comb begin
        last = ssl_pkg::FRAME_BITS - 4'h1;
        nrise = 4'($countones(rise));
        idx = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (rise[i]) begin
                idx = 4'(i);
            end
        end
        hit = rise[pos];
        sp = (pos == last) ? 4'h0 : pos + 4'h1;
        rel = (ph >= sp) ? ph - sp : ph - sp + ssl_pkg::FRAME_BITS;
    end

    // ------------------------------------------------------------
    // Lock state machine and outputs
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_cnt = cnt;
        next_init = init;
        next_win = w;
        next_prev = serial_in;
        next_dsh = dsh;
        next_ph = (ph == last) ? 4'h0 : ph + 4'h1;
        next_status = status;
        case (state)
            ssl_pkg::RX_INIT: begin
                // Reference clock must run to leave here
                next_init = init + 7'h1;
                if (init == ssl_pkg::RX_INIT_CYC - 7'h1) begin
                    next_state = ssl_pkg::RX_IDLE;
                end
            end
            ssl_pkg::RX_IDLE: begin
                if (serial_in != prev) begin
                    next_state = ssl_pkg::RX_HUNT;
                    next_cnt = 3'h0;
                end
            end
            ssl_pkg::RX_HUNT: begin
                // Only single-boundary words, such as sync words, count; others restart the run
                if (ph == last) begin
                    if (nrise == 4'h1) begin
                        next_pos = idx;
                        next_cnt = (cnt != 3'h0 && idx == pos) ? cnt + 3'h1 : 3'h1;
                        if (idx == pos && cnt == ssl_pkg::BOUNDARY_RUN - 3'h1) begin
                            next_state = ssl_pkg::RX_LOCK;
                            next_cnt = 3'h0;
                        end
                    end else begin
                        next_cnt = 3'h0;
                    end
                end
            end
            ssl_pkg::RX_LOCK: begin
                // Extra transitions do not matter while boundary holds
                if (ph == last) begin
                    next_cnt = hit ? 3'h0 : cnt + 3'h1;
                    if (!hit && cnt == ssl_pkg::BOUNDARY_RUN - 3'h1) begin
                        next_state = ssl_pkg::RX_HUNT;
                        next_cnt = 3'h0;
                    end
                end
                if (rel != 4'h0 && rel != last) begin
                    next_dsh[rel - 4'h1] = serial_in;
                end
            end
            default: begin
                next_state = ssl_pkg::RX_INIT;
            end
        endcase
        if (ph == last) begin
            next_status.repetitive_transition_pattern = nrise > 4'h1;
        end
        next_status.ready = next_state != ssl_pkg::RX_INIT;
        next_status.oe = next_state == ssl_pkg::RX_LOCK;
        next_status.lock_n = next_state != ssl_pkg::RX_LOCK;
        if (next_state == ssl_pkg::RX_LOCK) begin
            // Word changes with clock low, stable at its rise
            next_status.rclk = rel < ssl_pkg::RCLK_HIGH;
            if (rel == last) begin
                next_status.word = dsh;
            end
        end else begin
            next_status.rclk = 1'b0;
            next_status.word = 10'h000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ssl_pkg::RX_INIT;
            pos <= 4'h0;
            cnt <= 3'h0;
            init <= 7'h00;
            win <= 12'h000;
            prev <= 1'b0;
            dsh <= 10'h000;
            ph <= 4'h0;
            status <= '0;
            status.lock_n <= 1'b1;
        end else begin
            state <= next_state;
            pos <= next_pos;
            cnt <= next_cnt;
            init <= next_init;
            win <= next_win;
            prev <= next_prev;
            dsh <= next_dsh;
            ph <= next_ph;
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_lock_entry: assert property (
        state == ssl_pkg::RX_HUNT && next_state == ssl_pkg::RX_LOCK
        |-> ph == last && nrise == 4'h1 && idx == pos && cnt == 3'h3 ##1 !status.lock_n
    ) else $error("lock taken without four equal boundaries");
    a_rmt_blocks: assert property (
        state == ssl_pkg::RX_HUNT && ph == last && nrise > 4'h1 |=> cnt == 3'h0 && status.lock_n
    ) else $error("multi-transition word did not block lock");
    a_keep_lock: assert property (
        state == ssl_pkg::RX_LOCK && ph == last && hit |=> state == ssl_pkg::RX_LOCK && !status.lock_n
    ) else $error("lock lost although boundary held");
    a_loss_four: assert property (
        state == ssl_pkg::RX_LOCK && ph == last && !hit && cnt == 3'h3 |=> state == ssl_pkg::RX_HUNT
    ) else $error("lock kept after four missed boundaries");
    a_unlock_quiet: assert property (
        status.lock_n |-> !status.oe && !status.rclk && status.word == 10'h000
    ) else $error("outputs active while unlocked");
    a_edge_hunt: assert property (
        state == ssl_pkg::RX_IDLE && serial_in != prev |=> state == ssl_pkg::RX_HUNT
    ) else $error("input edge did not start acquisition");
    c_lock: cover property ($fell(status.lock_n));
    c_loss: cover property ($rose(status.lock_n) && status.ready);
endmodule // ssl_rx

//--- rtl/ssl_top.sv
`timescale 1ns/1ns
module ssl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transmit_word_clock,
    input wire logic [9:0] parallel_in_word,
    input wire logic sync_request_a,
    input wire logic sync_request_b,
    output logic serial_out,
    output logic serial_out_en,
    input wire logic serial_in,
    output logic [9:0] parallel_out_word,
    output logic parallel_out_en,
    output logic recovered_clock,
    output logic link_lock_n
);
    ssl_pkg::ssl_pins_type meta, pins;
    ssl_pkg::ssl_rx_type rx;
    logic wclk_prev, next_wclk_prev, tick, req;
    logic tx_ready, next_tx_ready, pending, next_pending;
    logic [4:0] tx_edges, next_tx_edges;
    logic [2:0] req_cnt, next_req_cnt;
    logic [10:0] burst_left, next_burst_left, tx_sh, next_tx_sh;
    logic next_serial_out, next_serial_out_en;
    logic aw_have, next_aw_have, w_have, next_w_have, do_wr, sw_sync;
    logic [3:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data, rd_word;
    logic wr_strb0, next_wr_strb0;
    logic txen, next_txen;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp, rd_resp;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages; only the second stage feeds any logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            pins <= '0;
        end else begin
            meta <= '{wclk: transmit_word_clock, req_a: sync_request_a, req_b: sync_request_b,
                      ser: serial_in, din: parallel_in_word};
            pins <= meta;
        end
    end

    // ------------------------------------------------------------
    // Deserializer
    // ------------------------------------------------------------
    ssl_rx u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .serial_in(pins.ser),
        .status(rx)
    );

    // Receive pins come straight from receiver flops
    assign parallel_out_word = rx.word;
    assign parallel_out_en = rx.oe;
    assign recovered_clock = rx.rclk;
    assign link_lock_n = rx.lock_n;

    // ------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------
    // Rising word clock edge marks a new frame
    assign tick = pins.wclk && !wclk_prev;
    assign req = pins.req_a || pins.req_b;

    always_comb begin
        next_wclk_prev = pins.wclk;
        next_tx_edges = tx_edges;
        next_tx_ready = tx_ready;
        next_req_cnt = req ? req_cnt : 3'h0;
        next_pending = pending;
        next_burst_left = burst_left;
        // One bit per system clock, twelve per word period
        next_tx_sh = {1'b0, tx_sh[10:1]};
        next_serial_out = tx_sh[0];
        // Driver stays off until the word clock has settled
        next_serial_out_en = tx_ready && txen;
        if (tick) begin
            if (!tx_ready) begin
                if (tx_edges == ssl_pkg::TX_INIT_EDGES - 5'h01) begin
                    next_tx_ready = 1'b1;
                end else begin
                    next_tx_edges = tx_edges + 5'h01;
                end
            end
            if (req && req_cnt != ssl_pkg::REQ_SAT) begin
                next_req_cnt = req_cnt + 3'h1;
            end
            // Start high, data low bit first, stop low
            next_serial_out = ssl_pkg::START_BIT;
            if (burst_left != 11'h000) begin
                next_tx_sh = {ssl_pkg::STOP_BIT, ssl_pkg::SYNC_DATA};
            end else begin
                next_tx_sh = {ssl_pkg::STOP_BIT, pins.din};
            end
            // Queued or still-held request restarts only at burst end
            if (burst_left > 11'h001) begin
                next_burst_left = burst_left - 11'h001;
            end else if (pending || req_cnt == ssl_pkg::REQ_SAT) begin
                next_burst_left = ssl_pkg::SYNC_BURST_WORDS;
                next_pending = 1'b0;
            end else begin
                next_burst_left = 11'h000;
            end
        end
        // Arming wins over consuming in the same cycle
        if (sw_sync || (tick && req && req_cnt == ssl_pkg::SYNC_MIN_WORDS)) begin
            next_pending = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wclk_prev <= 1'b0;
            tx_edges <= 5'h00;
            tx_ready <= 1'b0;
            req_cnt <= 3'h0;
            pending <= 1'b0;
            burst_left <= 11'h000;
            tx_sh <= 11'h000;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            wclk_prev <= next_wclk_prev;
            tx_edges <= next_tx_edges;
            tx_ready <= next_tx_ready;
            req_cnt <= next_req_cnt;
            pending <= next_pending;
            burst_left <= next_burst_left;
            tx_sh <= next_tx_sh;
            serial_out <= next_serial_out;
            serial_out_en <= next_serial_out_en;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Write executes once address and data are both held
    assign do_wr = aw_have && w_have && !s_axi_bvalid;
    assign sw_sync = do_wr && wr_addr == ssl_pkg::REG_CTRL && wr_strb0 && wr_data[ssl_pkg::CTRL_SYNC];

    // Read decode; unmapped offsets answer with an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = ssl_pkg::RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
            ssl_pkg::REG_CTRL: begin
                rd_word[ssl_pkg::CTRL_TXEN] = txen;
            end
            ssl_pkg::REG_STATUS: begin
                rd_word[ssl_pkg::ST_TX_READY] = tx_ready;
                rd_word[ssl_pkg::ST_BURST] = burst_left != 11'h000;
                rd_word[ssl_pkg::ST_LOCKED] = rx.oe;
                rd_word[ssl_pkg::ST_RMT] = rx.repetitive_transition_pattern;
                rd_word[ssl_pkg::ST_RX_READY] = rx.ready;
            end
            ssl_pkg::REG_RXWORD: begin
                rd_word[9:0] = rx.word;
            end
            default: begin
                rd_resp = ssl_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        next_aw_have = aw_have || (s_axi_awvalid && s_axi_awready);
        next_w_have = w_have || (s_axi_wvalid && s_axi_wready);
        next_wr_addr = (s_axi_awvalid && s_axi_awready) ? {s_axi_awaddr[3:2], 2'b00} : wr_addr;
        next_wr_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wr_data;
        next_wr_strb0 = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wr_strb0;
        next_txen = txen;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        if (do_wr) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            case (wr_addr)
                ssl_pkg::REG_CTRL: begin
                    next_bresp = ssl_pkg::RESP_OKAY;
                    if (wr_strb0) begin
                        next_txen = wr_data[ssl_pkg::CTRL_TXEN];
                    end
                end
                ssl_pkg::REG_STATUS, ssl_pkg::REG_RXWORD: begin
                    next_bresp = ssl_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = ssl_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_have;
        next_wready = !next_w_have;
        // One read in flight; address taken only while no answer pends
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_resp;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0000_0000;
            wr_strb0 <= 1'b0;
            txen <= ssl_pkg::CTRL_TXEN_RST;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ssl_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= ssl_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb0 <= next_wr_strb0;
            txen <= next_txen;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tx_quiet: assert property (
        !tx_ready |=> !serial_out_en
    ) else $error("serial driver enabled before initialization");
    a_frame_bits: assert property (
        tick && tx_ready |=> serial_out ##11 !serial_out
    ) else $error("frame lacks start or stop bit");
    a_sync_shape: assert property (
        tick && burst_left != 11'h000 |=> serial_out [*6] ##1 !serial_out [*6]
    ) else $error("sync word is not six ones then six zeros");
    a_burst_load: assert property (
        tick && burst_left == 11'h000 && pending && !sw_sync && !(req && req_cnt == ssl_pkg::SYNC_MIN_WORDS)
        |=> burst_left == ssl_pkg::SYNC_BURST_WORDS && !pending
    ) else $error("burst did not load full count");
    a_req_arms: assert property (
        tick && req && req_cnt == ssl_pkg::SYNC_MIN_WORDS |=> pending
    ) else $error("long request did not arm a burst");
    a_queue_hold: assert property (
        tick && burst_left > 11'h001 && pending |=> pending && burst_left == $past(burst_left) - 11'h001
    ) else $error("queued request disturbed running burst");
    a_ignore_input: assert property (
        tick && burst_left != 11'h000 |=> tx_sh[9:0] == ssl_pkg::SYNC_DATA
    ) else $error("parallel input used during sync burst");
    a_lock_pins: assert property (
        parallel_out_en |-> !link_lock_n
    ) else $error("outputs enabled while lock status high");
    c_burst: cover property (tick && burst_left == ssl_pkg::SYNC_BURST_WORDS);
    c_queued: cover property (pending && burst_left > 11'h001);
    c_write: cover property (do_wr && wr_addr == ssl_pkg::REG_CTRL);
endmodule // ssl_top
